// ### verilog/debug_entry_cause_capture.sv
// Debug entry cause capture and second breakpoint counter control.
// Assumes the core reaches the registers through the special register
// port below, and that event inputs other than the pins are on mclk.
`timescale 1ns/1ps
`default_nettype none

module debug_entry_cause_capture (
   input  wire logic                  mclk,
   input  wire logic                  rst,
   // Special register access port.
   input  wire logic [9:0]            spr_num,
   input  wire logic                  spr_rd,
   input  wire logic                  spr_wr,
   input  wire logic [31:0]           spr_wdata,
   output logic      [31:0]           spr_rdata_q,
   output logic                       spr_ack_q,
   // Debug mode state and entry mask.
   input  wire logic                  debug_enable,
   input  wire logic                  in_debug_mode,
   input  wire logic [31:0]           debug_entry_mask,
   // Pins from outside the clock domain.
   input  wire logic                  reset_pin_n,
   input  wire logic                  ext_bkpt_pin,
   // Core event sources.
   input  wire logic                  checkstop_entry,
   input  wire logic                  machine_check,
   input  wire logic                  mcheck_storage_err,
   input  wire logic                  ext_irq,
   input  wire logic                  align_exc,
   input  wire logic                  program_exc,
   input  wire logic                  fp_unavail_exc,
   input  wire logic                  decrementer_exc,
   input  wire logic                  syscall_exc,
   input  wire logic                  single_step_or_branch_hit,
   input  wire logic                  fp_assist_exc,
   input  wire logic                  sw_emulation_exc,
   input  wire logic                  instr_protect_err,
   input  wire logic                  data_protect_err,
   input  wire logic                  loadstore_bkpt,
   input  wire logic                  instr_bkpt,
   input  wire logic                  onchip_ext_bkpt,
   input  wire logic                  dev_port_bkpt,
   input  wire logic                  dev_port_nmi_req,
   input  wire logic                  debug_entry_from_reset,
   // Second watchpoints for the counter.
   input  wire logic                  instr_wp2_hit,
   input  wire logic                  loadstore_wp2_hit,
   // Results.
   output logic                       debug_entry_req_q,
   output logic      [15:0]           counter_preset_q,
   output dbg_cause_pkg::source_sel_e counter_source_select_q,
   output logic                       counter_tick_q
);
   import dbg_cause_pkg::*;

   // -----------------------------------------------------------------
   // Pin synchronisers
   // -----------------------------------------------------------------
   // The first stage feeds only the second stage.
   logic [SYNC_STAGES-1:0] rst_pin_sync_q;
   logic [SYNC_STAGES-1:0] bkpt_pin_sync_q;
   logic                   reset_pin_seen;
   logic                   ext_bkpt_seen;

   always_ff @(posedge mclk) begin
      if (rst) begin
         rst_pin_sync_q <= '1;
      end else begin
         rst_pin_sync_q <= {rst_pin_sync_q[0], reset_pin_n};
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         bkpt_pin_sync_q <= '0;
      end else begin
         bkpt_pin_sync_q <= {bkpt_pin_sync_q[0], ext_bkpt_pin};
      end
   end

   assign reset_pin_seen = ~rst_pin_sync_q[SYNC_STAGES-1];
   assign ext_bkpt_seen  = bkpt_pin_sync_q[SYNC_STAGES-1];

   // -----------------------------------------------------------------
   // Register decode
   // -----------------------------------------------------------------
   logic cause_sel;
   logic counter_sel;
   logic cause_read;
   logic cause_clear;
   logic counter_write;

   assign cause_sel     = (spr_num == SPR_CAUSE);
   assign counter_sel   = (spr_num == SPR_COUNTER_B);
   assign cause_read    = spr_rd & cause_sel;
   assign counter_write = spr_wr & counter_sel;

   // Reading while debug is armed but not yet entered must not lose the
   // cause that is about to steer entry, so the clear is held off then.
   assign cause_clear = cause_read
                        & (~debug_enable | in_debug_mode);

   // -----------------------------------------------------------------
   // Cause events
   // -----------------------------------------------------------------
   flag_if #(.WIDTH(32)) cause ();
   logic [31:0] set_vec;
   logic        mcheck_counts;
   logic        ext_bkpt_any;
   logic        port_req_any;

   assign mcheck_counts = machine_check & ~mcheck_storage_err;
   assign ext_bkpt_any  = onchip_ext_bkpt | dev_port_bkpt
                          | ext_bkpt_seen;
   assign port_req_any  = dev_port_nmi_req
                          | debug_entry_from_reset;

   always_comb begin
      set_vec               = '0;
      set_vec[B_RESET_PIN]  = reset_pin_seen;
      set_vec[B_CHECKSTOP]  = checkstop_entry;
      set_vec[B_MCHECK]     = mcheck_counts;
      set_vec[B_EXT_IRQ]    = ext_irq;
      set_vec[B_ALIGN]      = align_exc;
      set_vec[B_PROGRAM]    = program_exc;
      set_vec[B_FP_UNAVAIL] = fp_unavail_exc;
      set_vec[B_DECR]       = decrementer_exc;
      set_vec[B_SYSCALL]    = syscall_exc;
      set_vec[B_TRACE]      = single_step_or_branch_hit;
      set_vec[B_FP_ASSIST]  = fp_assist_exc;
      set_vec[B_SW_EMUL]    = sw_emulation_exc;
      set_vec[B_INSTR_PROT] = instr_protect_err;
      set_vec[B_DATA_PROT]  = data_protect_err;
      set_vec[B_LS_BKPT]    = loadstore_bkpt;
      set_vec[B_INSTR_BKPT] = instr_bkpt;
      set_vec[B_EXT_BKPT]   = ext_bkpt_any;
      set_vec[B_PORT_REQ]   = port_req_any;
   end

   // Only hardware events reach the store; the write data never does.
   assign cause.set_vec = set_vec;
   assign cause.clear   = cause_clear;

   sticky_flags #(
      .WIDTH (32),
      .VALID (CAUSE_VALID),
      .RST_V (CAUSE_RESET)
   ) u_cause (
      .mclk (mclk),
      .rst  (rst),
      .f    (cause.owner)
   );

   // -----------------------------------------------------------------
   // Debug entry request
   // -----------------------------------------------------------------
   // Only a cause raised this cycle asks for entry; an old flag that is
   // still sticky does not ask again.
   logic [31:0] entry_hits;

   assign entry_hits = set_vec & debug_entry_mask & CAUSE_VALID;

   always_ff @(posedge mclk) begin
      if (rst) begin
         debug_entry_req_q <= 1'b0;
      end else begin
         debug_entry_req_q <= debug_enable & ~in_debug_mode
                              & (|entry_hits);
      end
   end

   // -----------------------------------------------------------------
   // Breakpoint counter B
   // -----------------------------------------------------------------
   // The preset has no reset on purpose, so a value set before a reset
   // is still there after it.
   always_ff @(posedge mclk) begin
      if (counter_write) begin
         counter_preset_q <= spr_wdata[PRESET_MSB:PRESET_LSB];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         counter_source_select_q <= source_sel_e'(SELECT_RESET);
      end else if (counter_write) begin
         counter_source_select_q <=
            source_sel_e'(spr_wdata[SELECT_MSB:SELECT_LSB]);
      end
   end

   // The reserved code counts nothing, the same as disabled.
   always_ff @(posedge mclk) begin
      if (rst) begin
         counter_tick_q <= 1'b0;
      end else begin
         unique case (counter_source_select_q)
            SRC_OFF:      counter_tick_q <= 1'b0;
            SRC_INSTR_WP: counter_tick_q <= instr_wp2_hit;
            SRC_LS_WP:    counter_tick_q <= loadstore_wp2_hit;
            SRC_RESERVED: counter_tick_q <= 1'b0;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Read data and acknowledge
   // -----------------------------------------------------------------
   // Every access is acknowledged one cycle later; unknown numbers read
   // as zero so software never sees stale data.
   logic [31:0] counter_word;

   always_comb begin
      counter_word                        = '0;
      counter_word[PRESET_MSB:PRESET_LSB] = counter_preset_q;
      counter_word[SELECT_MSB:SELECT_LSB] = counter_source_select_q;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         spr_rdata_q <= '0;
      end else if (spr_rd) begin
         if (cause_sel) begin
            spr_rdata_q <= cause.flags & CAUSE_VALID;
         end else if (counter_sel) begin
            spr_rdata_q <= counter_word;
         end else begin
            spr_rdata_q <= '0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         spr_ack_q <= 1'b0;
      end else begin
         spr_ack_q <= spr_rd | spr_wr;
      end
   end

endmodule

`default_nettype wire

// ### verilog/dbg_cause_pkg.sv
// Constants for the debug entry cause capture block.
// Assumes register bit n in big-endian numbering sits at vector index
// 31-n, so bit 0 is the most significant bit.

`default_nettype none

package dbg_cause_pkg;

   // -----------------------------------------------------------------
   // Register numbers and layout
   // -----------------------------------------------------------------
   localparam logic [9:0]  SPR_CAUSE        = 10'h094;
   localparam logic [9:0]  SPR_COUNTER_B    = 10'h097;
   localparam logic [31:0] CAUSE_VALID      = 32'h73e7_540f;
   localparam logic [31:0] CAUSE_RESET      = 32'h0000_0000;
   localparam logic [1:0]  SELECT_RESET     = 2'h0;
   localparam int          PRESET_LSB       = 16;
   localparam int          PRESET_MSB       = 31;
   localparam int          SELECT_LSB       = 0;
   localparam int          SELECT_MSB       = 1;
   localparam int          SYNC_STAGES      = 2;

   // Cause bit positions as vector indices.
   localparam int B_RESET_PIN   = 30;
   localparam int B_CHECKSTOP   = 29;
   localparam int B_MCHECK      = 28;
   localparam int B_EXT_IRQ     = 25;
   localparam int B_ALIGN       = 24;
   localparam int B_PROGRAM     = 23;
   localparam int B_FP_UNAVAIL  = 22;
   localparam int B_DECR        = 21;
   localparam int B_SYSCALL     = 18;
   localparam int B_TRACE       = 17;
   localparam int B_FP_ASSIST   = 16;
   localparam int B_SW_EMUL     = 14;
   localparam int B_INSTR_PROT  = 12;
   localparam int B_DATA_PROT   = 10;
   localparam int B_LS_BKPT     = 3;
   localparam int B_INSTR_BKPT  = 2;
   localparam int B_EXT_BKPT    = 1;
   localparam int B_PORT_REQ    = 0;

   typedef enum logic [1:0] {
      SRC_OFF      = 2'h0,
      SRC_INSTR_WP = 2'h1,
      SRC_LS_WP    = 2'h2,
      SRC_RESERVED = 2'h3
   } source_sel_e;

endpackage

`default_nettype wire

// ### verilog/flag_if.sv
// Interface between the cause capture logic and its sticky flag store.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface flag_if #(parameter int WIDTH = 32);
   logic [WIDTH-1:0] set_vec;
   logic             clear;
   logic [WIDTH-1:0] flags;

   modport owner (input set_vec, input clear, output flags);
   modport user  (output set_vec, output clear, input flags);
endinterface

`default_nettype wire

// ### verilog/sticky_flags.sv
// Sticky flag store: hardware sets bits, one strobe clears all of them.
// Assumes set and clear come from logic on mclk.
`timescale 1ns/1ps
`default_nettype none

module sticky_flags #(
   parameter int               WIDTH = 32,
   parameter logic [WIDTH-1:0] VALID = '1,
   parameter logic [WIDTH-1:0] RST_V = '0
) (
   input wire logic mclk,
   input wire logic rst,
   flag_if.owner    f
);

   logic [WIDTH-1:0] flags_q;

   // -----------------------------------------------------------------
   // Storage
   // -----------------------------------------------------------------
   // A set in the same cycle as the clear survives, so no event is lost.
   always_ff @(posedge mclk) begin
      if (rst) begin
         flags_q <= RST_V;
      end else begin
         flags_q <= (flags_q & ~{WIDTH{f.clear}})
                    | (f.set_vec & VALID);
      end
   end

   assign f.flags = flags_q;

endmodule

`default_nettype wire

// ### tb/core_model.sv
// Partner model of the core event and second watchpoint sources.
// Assumes the bench asks for one event at a time, in step with mclk.
`timescale 1ns/1ps
`default_nettype none

module core_model (
   input  wire logic        mclk,
   input  wire logic        fire,
   input  wire logic [4:0]  code,
   output logic      [18:0] ev,
   output logic             iwp,
   output logic             lwp
);
   logic [3:0] cnt_q = 4'h0;

   // Events last one cycle, as the core raises them.
   always_ff @(posedge mclk) begin
      ev    <= fire ? 19'h1 << code : 19'h0;
      cnt_q <= cnt_q + 4'h1;
   end

   // The two hit streams differ so a wrong select shows on the tick.
   assign iwp = cnt_q[0];
   assign lwp = cnt_q[1] ^ cnt_q[2];
endmodule

`default_nettype wire

// ### tb/debug_entry_cause_capture_checker.sv
// Assertions on the ports of the debug entry cause capture block.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module debug_entry_cause_capture_checker (
   input wire logic                        mclk,
   input wire logic                        rst,
   input wire logic [9:0]                  spr_num,
   input wire logic                        spr_rd,
   input wire logic                        spr_wr,
   input wire logic [31:0]                 spr_wdata,
   input wire logic [31:0]                 spr_rdata_q,
   input wire logic                        spr_ack_q,
   input wire logic                        debug_enable,
   input wire logic                        in_debug_mode,
   input wire logic [31:0]                 debug_entry_mask,
   input wire logic                        ext_irq,
   input wire logic                        instr_wp2_hit,
   input wire logic                        loadstore_wp2_hit,
   input wire logic                        debug_entry_req_q,
   input wire logic [15:0]                 counter_preset_q,
   input wire dbg_cause_pkg::source_sel_e  counter_source_select_q,
   input wire logic                        counter_tick_q
);
   import dbg_cause_pkg::*;
   logic [15:0] wd_hi;

   assign wd_hi = spr_wdata[31:16];

   default clocking @(posedge mclk); endclocking
   default disable iff (rst);

   cause_wr_ack_a: assert property (
      spr_wr && spr_num == SPR_CAUSE |=> spr_ack_q)
      else $error("cause write not acknowledged");
   cause_rsvd_a: assert property (
      spr_rd && spr_num == SPR_CAUSE |=> (spr_rdata_q & ~CAUSE_VALID) == 0)
      else $error("reserved cause bit read as one");
   cntb_rsvd_a: assert property (
      spr_rd && spr_num == SPR_COUNTER_B |=> spr_rdata_q[15:2] == 14'h0)
      else $error("reserved counter bit read as one");
   unmapped_zero_a: assert property (
      spr_rd && spr_num != SPR_CAUSE && spr_num != SPR_COUNTER_B
      |=> spr_rdata_q == 32'h0)
      else $error("unmapped read not zero");
   preset_load_a: assert property (
      spr_wr && spr_num == SPR_COUNTER_B
      |=> counter_preset_q == $past(wd_hi))
      else $error("preset not loaded from write");
   sel_reset_a: assert property (
      $fell(rst) |-> counter_source_select_q == SRC_OFF && !counter_tick_q)
      else $error("select not cleared by reset");
   tick_instr_a: assert property (
      counter_source_select_q == SRC_INSTR_WP && !spr_wr
      |=> counter_tick_q == $past(instr_wp2_hit))
      else $error("tick does not follow instruction watchpoint");
   tick_ls_a: assert property (
      counter_source_select_q == SRC_LS_WP && !spr_wr
      |=> counter_tick_q == $past(loadstore_wp2_hit))
      else $error("tick does not follow load store watchpoint");
   tick_off_a: assert property (
      (counter_source_select_q == SRC_OFF ||
       counter_source_select_q == SRC_RESERVED) && !spr_wr |=> !counter_tick_q)
      else $error("tick while counting disabled");
   irq_entry_a: assert property (
      debug_enable && !in_debug_mode && ext_irq && debug_entry_mask[B_EXT_IRQ]
      |=> debug_entry_req_q)
      else $error("unmasked interrupt gave no entry request");
   no_entry_a: assert property (
      !debug_enable || in_debug_mode |=> !debug_entry_req_q)
      else $error("entry request while disabled or in debug");

   cause_read_c: cover property (spr_rd && spr_num == SPR_CAUSE);
   entry_req_c: cover property (debug_entry_req_q);
   tick_c: cover property (counter_tick_q);
endmodule

bind debug_entry_cause_capture debug_entry_cause_capture_checker u_chk (.*);

`default_nettype wire

// ### tb/debug_entry_cause_capture_test.sv
// Self-checking bench for the debug entry cause capture block.
// Assumes the package, flag interface and design files compile first.
`timescale 1ns/1ps
`default_nettype none

module debug_entry_cause_capture_test;
   import dbg_cause_pkg::*;
   localparam int BIT_OF [19] = '{B_CHECKSTOP, B_MCHECK, B_EXT_IRQ,
      B_ALIGN, B_PROGRAM, B_FP_UNAVAIL, B_DECR, B_SYSCALL, B_TRACE,
      B_FP_ASSIST, B_SW_EMUL, B_INSTR_PROT, B_DATA_PROT, B_LS_BKPT,
      B_INSTR_BKPT, B_EXT_BKPT, B_EXT_BKPT, B_PORT_REQ, B_PORT_REQ};
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic [9:0]  spr_num = 10'h0;
   logic        spr_rd = 1'b0;
   logic        spr_wr = 1'b0;
   logic [31:0] spr_wdata = 32'h0;
   logic        debug_enable = 1'b0;
   logic        in_debug_mode = 1'b0;
   logic [31:0] debug_entry_mask = 32'h0;
   logic        reset_pin_n = 1'b1;
   logic        ext_bkpt_pin = 1'b0;
   logic        mcheck_storage_err = 1'b0;
   logic        fire = 1'b0;
   logic [4:0]  code = 5'h0;
   logic [18:0] ev;
   logic        instr_wp2_hit;
   logic        loadstore_wp2_hit;
   logic [31:0] spr_rdata_q;
   logic        spr_ack_q;
   logic        debug_entry_req_q;
   logic        counter_tick_q;
   logic [15:0] counter_preset_q;
   source_sel_e counter_source_select_q;
   logic [31:0] d;
   int          failures = 0;
   int          check_count = 0;
   int          cyc = 0;

   core_model u_model (.mclk(mclk), .fire(fire), .code(code), .ev(ev),
      .iwp(instr_wp2_hit), .lwp(loadstore_wp2_hit));

   debug_entry_cause_capture u_dut (.*, .checkstop_entry(ev[0]),
      .machine_check(ev[1]), .ext_irq(ev[2]), .align_exc(ev[3]),
      .program_exc(ev[4]), .fp_unavail_exc(ev[5]), .decrementer_exc(ev[6]),
      .syscall_exc(ev[7]), .single_step_or_branch_hit(ev[8]),
      .fp_assist_exc(ev[9]), .sw_emulation_exc(ev[10]),
      .instr_protect_err(ev[11]), .data_protect_err(ev[12]),
      .loadstore_bkpt(ev[13]), .instr_bkpt(ev[14]), .onchip_ext_bkpt(ev[15]),
      .dev_port_bkpt(ev[16]), .dev_port_nmi_req(ev[17]),
      .debug_entry_from_reset(ev[18]));

   always #25 mclk = ~mclk;

   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         test_done;
      end
   end

   function automatic logic [31:0] flag_of(input int k);
      return 32'h1 << BIT_OF[k];
   endfunction

   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] s);
      check_count++;
      if (s !== e) begin
         failures++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask

   // Each access leaves one idle cycle, so strobes never merge.
   task automatic acc(input logic [9:0] a, input logic w,
                      input logic [31:0] wd);
      @(posedge mclk) #1;
      spr_num = a;
      spr_rd = !w;
      spr_wr = w;
      spr_wdata = wd;
      @(posedge mclk) #1;
      spr_rd = 1'b0;
      spr_wr = 1'b0;
      chk("ack", 32'h1, {31'h0, spr_ack_q});
   endtask

   task automatic hit(input int k);
      @(posedge mclk) #1;
      fire = 1'b1;
      code = k[4:0];
      @(posedge mclk) #1;
      fire = 1'b0;
   endtask

   task automatic test_done;
      if (failures == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      int k;
      d = $urandom(12073);
      repeat (6) @(posedge mclk);
      #1 rst = 1'b0;
      acc(SPR_CAUSE, 1'b0, 32'h0);
      chk("cause", CAUSE_RESET, spr_rdata_q);
      acc(SPR_COUNTER_B, 1'b0, 32'h0);
      chk("cntb", 32'h0, spr_rdata_q & 32'hffff);
      acc(10'h095, 1'b0, 32'h0);
      chk("unmapped", 32'h0, spr_rdata_q);
      for (int s = 0; s < 4; s++) begin
         d = $urandom;
         acc(SPR_COUNTER_B, 1'b1, {d[31:2], 2'(s)});
         repeat (6) @(posedge mclk);
         acc(SPR_COUNTER_B, 1'b0, 32'h0);
         chk("cntb", {d[31:16], 14'h0, 2'(s)}, spr_rdata_q);
      end
      @(posedge mclk) #1;
      rst = 1'b1;
      repeat (3) @(posedge mclk);
      #1 rst = 1'b0;
      acc(SPR_COUNTER_B, 1'b0, 32'h0);
      chk("cntb", {d[31:16], 16'h0}, spr_rdata_q);
      for (k = 0; k < 19; k++) begin
         hit(k);
         acc(SPR_CAUSE, 1'b0, 32'h0);
         chk("flag", flag_of(k), spr_rdata_q);
         acc(SPR_CAUSE, 1'b0, 32'h0);
         chk("cleared", 32'h0, spr_rdata_q);
      end
      hit(2);
      acc(SPR_CAUSE, 1'b1, 32'hffff_ffff);
      acc(SPR_CAUSE, 1'b0, 32'h0);
      chk("written", flag_of(2), spr_rdata_q);
      mcheck_storage_err = 1'b1;
      hit(1);
      @(posedge mclk) #1;
      mcheck_storage_err = 1'b0;
      acc(SPR_CAUSE, 1'b0, 32'h0);
      chk("storage", 32'h0, spr_rdata_q);
      debug_enable = 1'b1;
      for (int i = 0; i < 8; i++) begin
         debug_entry_mask = i ? $urandom : 32'hffff_ffff;
         k = i ? $urandom_range(18) : 2;
         in_debug_mode = i[0];
         hit(k);
         @(posedge mclk) #1;
         chk("entry", {31'h0, !i[0] && debug_entry_mask[BIT_OF[k]]},
            {31'h0, debug_entry_req_q});
         acc(SPR_CAUSE, 1'b0, 32'h0);
         chk("held", flag_of(k), spr_rdata_q);
         acc(SPR_CAUSE, 1'b0, 32'h0);
         chk("kept", i[0] ? 32'h0 : flag_of(k), spr_rdata_q);
         in_debug_mode = 1'b1;
         acc(SPR_CAUSE, 1'b0, 32'h0);
      end
      debug_enable = 1'b0;
      in_debug_mode = 1'b0;
      @(posedge mclk) #1;
      reset_pin_n = 1'b0;
      ext_bkpt_pin = 1'b1;
      repeat (3) @(posedge mclk);
      #1 reset_pin_n = 1'b1;
      ext_bkpt_pin = 1'b0;
      repeat (4) @(posedge mclk);
      acc(SPR_CAUSE, 1'b0, 32'h0);
      chk("pins", 32'h1 << B_RESET_PIN | 32'h1 << B_EXT_BKPT,
         spr_rdata_q);
      test_done;
   end
endmodule

`default_nettype wire
